// *** verilog/wpr_pkg.sv ***
package wpr_pkg;
   // APB byte addresses (one word per register)
   localparam logic [7:0] ADDR_WDT_CTRL = 8'h00;
   localparam logic [7:0] ADDR_PWR_CTRL = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_WDT_COUNT = 8'h0c;
   // Watchdog control field positions
   localparam int WDT_EN_BIT = 7;
   localparam int WDT_RESTART_BIT = 6;
   localparam int WDT_IDLE_RUN_BIT = 3;
   localparam int WDT_PS_HI_BIT = 2;
   localparam int WDT_PS_MID_BIT = 1;
   localparam int WDT_PS_LO_BIT = 0;
   // Power control field positions
   localparam int PWR_IDLE_BIT = 0;
   localparam int PWR_PDOWN_BIT = 1;
   localparam int PWR_KEEP_BIT = 4;
   // Reset values
   localparam logic [7:0] WDT_CTRL_RST = 8'h00;
   localparam logic [7:0] PWR_CTRL_RST = 8'h00;
   localparam logic [7:0] PORT_RST = 8'hff;
   localparam logic [7:0] STACK_PTR_RST = 8'h07;
   localparam logic [7:0] SFR_RST = 8'h00;
   // Timing
   localparam int OSC_PER_MCYCLE = 12;
   localparam int RST_HOLD_MCYCLES = 2;
   localparam int RST_HOLD_CLKS = OSC_PER_MCYCLE * RST_HOLD_MCYCLES;
   localparam int RST_SAMPLE_PHASE = 9;
   localparam int WDT_CNT_BITS = 14;
   localparam int PS_BITS = 8;
   localparam int MCYCLE_W = 4;
endpackage : wpr_pkg

// *** verilog/wpr_watchdog.sv ***
// Behaviour
// - Idle request stops the processor clock; peripherals and interrupts stay clocked.
// - Idle ends on an interrupt or a reset.
// - Power-down request stops every clock, oscillator included.
// - Power-down ignores interrupts; only reset leaves it.
// - Reset pin sampled once per machine cycle; needs two machine cycles high.
// - Reset input filtered so glitches and slow RC edges are ignored.
// - Reset loads ports FFH, stack 07H, power control 00H except bit 4.
// - Free-running divider chain; selected output times out and may reset the system.
// - System reset disables the watchdog and clears its counter.
// - Watchdog counts and times out only while enabled.
// - Writing restart bit clears counter, prescaler and the bit next machine cycle.
// - Watchdog runs in idle only with run-in-idle bit set; resets to zero.
// - Prescale select 000=2,010=4,001=8,011=16,100=32,101=64,110=128,111=256.
// - Time-out is oscillator period times 12 times 2^14 times prescale ratio.
//
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module wpr_watchdog (
   input wire logic clock,
   input wire logic rst,
   input wire logic reset_pin,
   input wire logic irq_pending,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic cpu_clk_en,
   output logic periph_clk_en,
   output logic osc_run,
   output logic sys_reset,
   output logic [7:0] port_init,
   output logic [7:0] stack_init,
   output logic [7:0] sfr_init
);
   typedef enum logic [1:0] {
      WPR_RUN = 2'b00,
      WPR_IDLE = 2'b01,
      WPR_PDOWN = 2'b10
   } wpr_mode_t;

   localparam int MCYCLE_W_T = wpr_pkg::MCYCLE_W;
   localparam logic [MCYCLE_W_T-1:0] PHASE_LAST = MCYCLE_W_T'(wpr_pkg::OSC_PER_MCYCLE - 1);
   localparam logic [MCYCLE_W_T-1:0] PHASE_SAMPLE = MCYCLE_W_T'(wpr_pkg::RST_SAMPLE_PHASE);
   localparam logic [1:0] HOLD_NEED = 2'(wpr_pkg::RST_HOLD_MCYCLES);

   wpr_mode_t mode_q, mode_d;
   logic pin_s1_q, pin_s2_q;
   logic [MCYCLE_W_T-1:0] phase_q;
   logic [1:0] hi_cnt_q;
   logic rst_cond_q;
   logic wdt_fire_q;
   logic [7:0] wdt_ctrl_q, pwr_ctrl_q;
   logic [7:0] ps_q;
   logic [wpr_pkg::WDT_CNT_BITS-1:0] cnt_q;
   logic restart_pend_q;
   logic [31:0] prdata_q;
   logic pready_q, pslverr_q, cpu_en_q, per_en_q, osc_q, sys_rst_q;
   logic [7:0] port_q, stack_q, sfr_q;

   wire mcycle_end = (phase_q == PHASE_LAST);
   wire sample_pt = (phase_q == PHASE_SAMPLE);
   wire internal_rst = rst_cond_q | wdt_fire_q;
   wire setup = psel & ~penable;
   wire acc = psel & penable;
   wire wr_acc = acc & pwrite;
   wire a_wdt = (paddr == wpr_pkg::ADDR_WDT_CTRL);
   wire a_pwr = (paddr == wpr_pkg::ADDR_PWR_CTRL);
   wire a_sts = (paddr == wpr_pkg::ADDR_STATUS);
   wire a_cnt = (paddr == wpr_pkg::ADDR_WDT_COUNT);
   wire a_ok = a_wdt | a_pwr | a_sts | a_cnt;
   wire wr_wdt = wr_acc & a_wdt;
   wire wr_pwr = wr_acc & a_pwr;
   wire wdt_en = wdt_ctrl_q[wpr_pkg::WDT_EN_BIT];
   wire idle_run = wdt_ctrl_q[wpr_pkg::WDT_IDLE_RUN_BIT];
   wire [2:0] ps_sel = {wdt_ctrl_q[wpr_pkg::WDT_PS_HI_BIT], wdt_ctrl_q[wpr_pkg::WDT_PS_MID_BIT],
      wdt_ctrl_q[wpr_pkg::WDT_PS_LO_BIT]};
   // Selection ladder is not monotonic in the code; mid bit alone gives 4
   wire [2:0] ps_tap = (ps_sel == 3'h0) ? 3'h0 :
                       (ps_sel == 3'h2) ? 3'h1 :
                       (ps_sel == 3'h1) ? 3'h2 :
                       (ps_sel == 3'h3) ? 3'h3 : ps_sel;
   wire [7:0] ps_mask = 8'((9'h002 << ps_tap) - 9'h001);
   // Counting gated by enable, idle policy and power-down
   wire wdt_run = wdt_en & (mode_q == WPR_RUN || (mode_q == WPR_IDLE && idle_run));
   wire ps_tick = wdt_run & mcycle_end & ((ps_q & ps_mask) == ps_mask);
   wire timeout = ps_tick & (&cnt_q);
   wire [7:0] wdt_rd = wdt_ctrl_q & 8'hcf;
   wire [31:0] rd_mux = a_wdt ? {24'h0, wdt_rd} :
                        a_pwr ? {24'h0, pwr_ctrl_q} :
                        a_sts ? {28'h0, restart_pend_q, sys_rst_q, 2'(mode_q)} :
                        a_cnt ? {18'h0, cnt_q} : 32'h0;

   // Machine-cycle phase; the oscillator stops in power-down so the phase freezes too.
   // A high reset pin restarts it, otherwise the pin could never be sampled to leave power-down.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) phase_q <= '0;
      else if (mode_q == WPR_PDOWN && !pin_s2_q) phase_q <= phase_q;
      else phase_q <= mcycle_end ? '0 : phase_q + MCYCLE_W_T'(1);
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pin_s1_q <= 1'b0;
         pin_s2_q <= 1'b0;
      end else begin
         pin_s1_q <= reset_pin;
         pin_s2_q <= pin_s1_q;
      end
   end

   // Pin is seen only at one phase per machine cycle, so short pulses between samples vanish;
   // a low sample restarts the count, which cleans up a slow RC edge
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         hi_cnt_q <= 2'h0;
         rst_cond_q <= 1'b0;
      end else if (sample_pt) begin
         if (!pin_s2_q) begin
            hi_cnt_q <= 2'h0;
            rst_cond_q <= 1'b0;
         end else if (hi_cnt_q + 2'h1 >= HOLD_NEED) begin
            hi_cnt_q <= HOLD_NEED;
            rst_cond_q <= 1'b1;
         end else begin
            hi_cnt_q <= hi_cnt_q + 2'h1;
         end
      end
   end

   // Idle leaves on interrupt; power-down ignores it
   always_comb begin
      mode_d = mode_q;
      case (mode_q)
         WPR_RUN: begin
            if (wr_pwr && pwdata[wpr_pkg::PWR_PDOWN_BIT]) mode_d = WPR_PDOWN;
            else if (wr_pwr && pwdata[wpr_pkg::PWR_IDLE_BIT]) mode_d = WPR_IDLE;
         end
         WPR_IDLE: begin
            if (irq_pending) mode_d = WPR_RUN;
         end
         WPR_PDOWN: mode_d = WPR_PDOWN;
         default: mode_d = WPR_RUN;
      endcase
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) mode_q <= WPR_RUN;
      else if (internal_rst) mode_q <= WPR_RUN;
      else mode_q <= mode_d;
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) pwr_ctrl_q <= wpr_pkg::PWR_CTRL_RST;
      else if (internal_rst) pwr_ctrl_q <= pwr_ctrl_q & (8'h01 << wpr_pkg::PWR_KEEP_BIT);
      else if (mode_q == WPR_IDLE && mode_d == WPR_RUN) pwr_ctrl_q[wpr_pkg::PWR_IDLE_BIT] <= 1'b0;
      else if (wr_pwr) pwr_ctrl_q <= pwdata[7:0];
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) wdt_ctrl_q <= wpr_pkg::WDT_CTRL_RST;
      else if (internal_rst) wdt_ctrl_q <= wpr_pkg::WDT_CTRL_RST;
      else if (wr_wdt) wdt_ctrl_q <= pwdata[7:0] & 8'hcf;
      else if (restart_pend_q && mcycle_end) wdt_ctrl_q[wpr_pkg::WDT_RESTART_BIT] <= 1'b0;
   end

   // Restart takes hold at the end of the machine cycle after the write
   always_ff @(posedge clock or posedge rst) begin
      if (rst) restart_pend_q <= 1'b0;
      else if (internal_rst) restart_pend_q <= 1'b0;
      else if (wr_wdt && pwdata[wpr_pkg::WDT_RESTART_BIT]) restart_pend_q <= 1'b1;
      else if (mcycle_end) restart_pend_q <= 1'b0;
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ps_q <= 8'h00;
         cnt_q <= '0;
      end else if (internal_rst || (restart_pend_q && mcycle_end)) begin
         ps_q <= 8'h00;
         cnt_q <= '0;
      end else if (wdt_run && mcycle_end) begin
         ps_q <= ps_tick ? 8'h00 : ps_q + 8'h01;
         if (ps_tick) cnt_q <= cnt_q + {{(wpr_pkg::WDT_CNT_BITS-1){1'b0}}, 1'b1};
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) wdt_fire_q <= 1'b0;
      else wdt_fire_q <= timeout & ~restart_pend_q;
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         prdata_q <= 32'h0;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q <= setup;
         pslverr_q <= setup & ~a_ok;
         prdata_q <= (setup & ~pwrite) ? rd_mux : prdata_q;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cpu_en_q <= 1'b0;
         per_en_q <= 1'b0;
         osc_q <= 1'b1;
         sys_rst_q <= 1'b1;
         port_q <= wpr_pkg::PORT_RST;
         stack_q <= wpr_pkg::STACK_PTR_RST;
         sfr_q <= wpr_pkg::SFR_RST;
      end else begin
         cpu_en_q <= (mode_d == WPR_RUN) & ~internal_rst;
         per_en_q <= (mode_d != WPR_PDOWN);
         osc_q <= (mode_d != WPR_PDOWN);
         sys_rst_q <= internal_rst;
         port_q <= wpr_pkg::PORT_RST;
         stack_q <= wpr_pkg::STACK_PTR_RST;
         sfr_q <= wpr_pkg::SFR_RST;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign cpu_clk_en = cpu_en_q;
   assign periph_clk_en = per_en_q;
   assign osc_run = osc_q;
   assign sys_reset = sys_rst_q;
   assign port_init = port_q;
   assign stack_init = stack_q;
   assign sfr_init = sfr_q;

   property p_idle_stops_cpu;
      @(posedge clock) disable iff (rst) (mode_q == WPR_IDLE) |-> ##1 !cpu_clk_en || $past(irq_pending);
   endproperty
   a_idle_stops_cpu: assert property (p_idle_stops_cpu) else $error("cpu clock runs in idle");

   property p_idle_periph;
      @(posedge clock) disable iff (rst) (mode_q == WPR_IDLE) |=> periph_clk_en;
   endproperty
   a_idle_periph: assert property (p_idle_periph) else $error("peripheral clock stopped in idle");

   property p_idle_wake;
      @(posedge clock) disable iff (rst) (mode_q == WPR_IDLE && irq_pending) |=> mode_q == WPR_RUN;
   endproperty
   a_idle_wake: assert property (p_idle_wake) else $error("idle did not end on interrupt");

   property p_pdown_osc;
      @(posedge clock) disable iff (rst) (mode_q == WPR_PDOWN && !internal_rst) |=> !osc_run;
   endproperty
   a_pdown_osc: assert property (p_pdown_osc) else $error("oscillator runs in power-down");

   property p_pdown_stays;
      @(posedge clock) disable iff (rst) (mode_q == WPR_PDOWN && !internal_rst) |=> mode_q == WPR_PDOWN;
   endproperty
   a_pdown_stays: assert property (p_pdown_stays) else $error("power-down left without reset");

   // Two high samples one machine cycle apart are needed before reset is taken
   property p_reset_needs_hold;
      @(posedge clock) disable iff (rst)
         $rose(rst_cond_q) |-> $past(sample_pt) && $past(pin_s2_q) && $past(pin_s2_q, wpr_pkg::OSC_PER_MCYCLE + 1);
   endproperty
   a_reset_needs_hold: assert property (p_reset_needs_hold) else $error("reset taken off sample point");

   property p_timeout_resets;
      @(posedge clock) disable iff (rst) (timeout && !restart_pend_q) |-> ##2 sys_reset;
   endproperty
   a_timeout_resets: assert property (p_timeout_resets) else $error("time-out did not reset the system");

   property p_wdt_reset_clears;
      @(posedge clock) disable iff (rst) wdt_fire_q |=> !wdt_en && cnt_q == '0;
   endproperty
   a_wdt_reset_clears: assert property (p_wdt_reset_clears) else $error("watchdog not cleared by reset");

   property p_disabled_holds;
      @(posedge clock) disable iff (rst) (!wdt_en && !internal_rst) |=> $stable(cnt_q) || cnt_q == '0;
   endproperty
   a_disabled_holds: assert property (p_disabled_holds) else $error("counter moved while disabled");

   property p_disabled_no_fire;
      @(posedge clock) disable iff (rst) !wdt_en |=> !wdt_fire_q;
   endproperty
   a_disabled_no_fire: assert property (p_disabled_no_fire) else $error("watchdog fired while disabled");

   property p_restart;
      @(posedge clock) disable iff (rst) (restart_pend_q && mcycle_end) |=> cnt_q == '0 && ps_q == 8'h00;
   endproperty
   a_restart: assert property (p_restart) else $error("restart did not clear counter");

   property p_idle_policy;
      @(posedge clock) disable iff (rst) (mode_q == WPR_IDLE && !idle_run && !internal_rst) |=> $stable(cnt_q);
   endproperty
   a_idle_policy: assert property (p_idle_policy) else $error("counter ran in idle");

   property p_pdown_hold;
      @(posedge clock) disable iff (rst) (mode_q == WPR_PDOWN) |=> !wdt_fire_q;
   endproperty
   a_pdown_hold: assert property (p_pdown_hold) else $error("watchdog fired in power-down");
endmodule : wpr_watchdog

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb;
   logic clock, rst, reset_pin, irq_pending, psel, penable, pwrite, pready, pslverr;
   logic cpu_clk_en, periph_clk_en, osc_run, sys_reset, err, seen_rst;
   logic [7:0] paddr, port_init, stack_init, sfr_init;
   logic [31:0] pwdata, prdata, rdv, cnt;
   int fail_count, total_checks, n;
   int ratio [8];
   wpr_watchdog i_dut (.clock(clock), .rst(rst), .reset_pin(reset_pin), .irq_pending(irq_pending),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
      .osc_run(osc_run), .sys_reset(sys_reset), .port_init(port_init), .stack_init(stack_init),
      .sfr_init(sfr_init));
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   always @(posedge clock) if (sys_reset === 1'b1) seen_rst <= 1'b1;
   task automatic tick(input int k);
      repeat (k) @(posedge clock);
   endtask : tick
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, got);
      end
   endtask : chk
   // Counts drift by one with the phase of the machine cycle, so a window is allowed
   task automatic rng(input string nm, input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] got);
      total_checks++;
      if ((^got === 1'bx) || got < lo || got > hi) begin
         fail_count++;
         $display("unexpected %s: expected %0d..%0d, seen %h", nm, lo, hi, got);
      end
   endtask : rng
   // Called just after a rising edge; returns one idle cycle after release
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int w;
      w = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
         w++;
      end while (pready !== 1'b1 && w < 20);
      rdv = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chk("pready", 1'b1, pready);
      @(posedge clock);
   endtask : apb
   task automatic test_done();
      $display("checks %0d, mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : test_done
   initial begin
      tick(60000);
      fail_count++;
      $display("unexpected timeout: expected end of tests, seen none");
      test_done();
   end
   initial begin
      ratio = '{2, 8, 4, 16, 32, 64, 128, 256};
      {rst, reset_pin, irq_pending, psel, penable, pwrite, seen_rst} = 7'h40;
      paddr = 8'h00;
      pwdata = 32'h0;
      tick(10);
      rst <= 1'b0;
      tick(1);
      chk("port_init", 8'hff, port_init);
      chk("stack_init", 8'h07, stack_init);
      chk("sfr_init", 8'h00, sfr_init);
      apb(0, wpr_pkg::ADDR_WDT_CTRL, 0);
      chk("wdt_ctrl", 32'h0, rdv);
      apb(0, wpr_pkg::ADDR_PWR_CTRL, 0);
      chk("pwr_ctrl", 32'h0, rdv);
      apb(0, 8'h10, 0);
      chk("pslverr", 1'b1, err);
      chk("unmapped", 32'h0, rdv);
      $display("test reset values done");
      apb(1, wpr_pkg::ADDR_WDT_CTRL, 32'h37);
      apb(0, wpr_pkg::ADDR_WDT_CTRL, 0);
      chk("wdt_ctrl mask", 32'h07, rdv);
      tick(300);
      apb(0, wpr_pkg::ADDR_WDT_COUNT, 0);
      chk("count disabled", 32'h0, rdv);
      $display("test disabled done");
      for (int i = 0; i < 8; i++) begin
         apb(1, wpr_pkg::ADDR_WDT_CTRL, 32'hc0 | i);
         tick(12 * ratio[i] * 4);
         apb(0, wpr_pkg::ADDR_WDT_COUNT, 0);
         rng("count rate", 3, 5, rdv);
      end
      $display("test prescale done");
      apb(1, wpr_pkg::ADDR_WDT_CTRL, 32'h80);
      tick(600);
      apb(1, wpr_pkg::ADDR_WDT_CTRL, 32'hc0);
      tick(12);
      apb(0, wpr_pkg::ADDR_WDT_CTRL, 0);
      chk("restart self clear", 32'h80, rdv);
      apb(0, wpr_pkg::ADDR_WDT_COUNT, 0);
      rng("count restart", 0, 1, rdv);
      $display("test restart done");
      for (int k = 0; k < 2; k++) begin
         apb(1, wpr_pkg::ADDR_WDT_CTRL, k ? 32'h88 : 32'h80);
         apb(1, wpr_pkg::ADDR_PWR_CTRL, 32'h01);
         tick(2);
         chk("cpu idle", 1'b0, cpu_clk_en);
         chk("periph idle", 1'b1, periph_clk_en);
         apb(0, wpr_pkg::ADDR_STATUS, 0);
         chk("mode idle", 32'h1, rdv & 32'h3);
         apb(0, wpr_pkg::ADDR_WDT_COUNT, 0);
         cnt = rdv;
         tick(240);
         apb(0, wpr_pkg::ADDR_WDT_COUNT, 0);
         rng("count idle", k ? cnt + 8 : cnt, k ? cnt + 12 : cnt, rdv);
         irq_pending <= 1'b1;
         n = 0;
         do begin
            @(posedge clock);
            n++;
         end while (cpu_clk_en !== 1'b1 && n < 50);
         chk("cpu wake", 1'b1, cpu_clk_en);
         irq_pending <= 1'b0;
         tick(1);
      end
      $display("test idle done");
      apb(1, wpr_pkg::ADDR_PWR_CTRL, 32'h02);
      tick(2);
      chk("osc pdown", 1'b0, osc_run);
      chk("periph pdown", 1'b0, periph_clk_en);
      irq_pending <= 1'b1;
      seen_rst <= 1'b0;
      tick(50);
      chk("cpu pdown irq", 1'b0, cpu_clk_en);
      chk("no wdt reset", 1'b0, seen_rst);
      irq_pending <= 1'b0;
      rst <= 1'b1;
      tick(2);
      rst <= 1'b0;
      tick(2);
      chk("osc after reset", 1'b1, osc_run);
      chk("cpu after reset", 1'b1, cpu_clk_en);
      $display("test power-down done");
      apb(1, wpr_pkg::ADDR_WDT_CTRL, 32'h80);
      apb(1, wpr_pkg::ADDR_PWR_CTRL, 32'h10);
      seen_rst <= 1'b0;
      reset_pin <= 1'b1;
      tick(1);
      reset_pin <= 1'b0;
      tick(48);
      chk("glitch ignored", 1'b0, seen_rst);
      reset_pin <= 1'b1;
      tick(36);
      reset_pin <= 1'b0;
      tick(30);
      chk("pin reset", 1'b1, seen_rst);
      n = 0;
      while (sys_reset !== 1'b0 && n < 60) begin
         @(posedge clock);
         n++;
      end
      chk("sys_reset release", 1'b0, sys_reset);
      tick(2);
      apb(0, wpr_pkg::ADDR_WDT_CTRL, 0);
      chk("wdt_ctrl after pin", 32'h0, rdv);
      apb(0, wpr_pkg::ADDR_WDT_COUNT, 0);
      rng("count after pin", 0, 0, rdv);
      apb(0, wpr_pkg::ADDR_PWR_CTRL, 0);
      chk("pwr keep bit", 32'h10, rdv);
      $display("test pin reset done");
      apb(1, wpr_pkg::ADDR_PWR_CTRL, 32'h02);
      seen_rst <= 1'b0;
      reset_pin <= 1'b1;
      tick(36);
      reset_pin <= 1'b0;
      tick(30);
      chk("pdown pin reset", 1'b1, seen_rst);
      tick(30);
      chk("osc after pin", 1'b1, osc_run);
      $display("test power-down pin done");
      test_done();
   end
endmodule : tb
